// ===== logic/alf_framer.sv
/*
  alf_framer: lvds output framer top. parallel ddr output in bypass, serial
  framed output with frame clock on lane zero when decimating; avalon-mm
  register slave with waitrequest.
  assumes: one clock cycle models one data bit clock period; LANE_RISE_O and
  LANE_FALL_O are the bits for its rising and falling edge. band words arrive
  on BAND_DATA_I with a one-cycle BAND_LOAD_I; samples on SMP_A_I/SMP_B_I.
*/
`timescale 1ns/1ns
module alf_framer (
  // clock and reset
  input  wire logic                        REF_CLK_I,
  input  wire logic                        RST_N_I,
  // avalon-mm slave
  input  wire logic [7:0]                  AVS_ADDRESS_I,
  input  wire logic                        AVS_READ_I,
  input  wire logic                        AVS_WRITE_I,
  input  wire logic [31:0]                 AVS_WRITEDATA_I,
  input  wire logic [3:0]                  AVS_BYTEENABLE_I,
  output logic [31:0]                      AVS_READDATA_O,
  output logic                             AVS_WAITREQUEST_O,
  // sample sources
  input  wire logic [alf_pkg::SAMPLE_W-1:0] SMP_A_I,
  input  wire logic [alf_pkg::SAMPLE_W-1:0] SMP_B_I,
  input  wire logic [alf_pkg::FRAME_W-1:0]  BAND_DATA_I,
  input  wire logic                        BAND_LOAD_I,
  // lvds lanes
  output logic [alf_pkg::NUM_LANES-1:0]    LANE_RISE_O,
  output logic [alf_pkg::NUM_LANES-1:0]    LANE_FALL_O,
  // status pins
  output logic                             SERIAL_OUTPUT_MODE_O,
  output logic                             BIT_CLK_DIV_O,
  output logic                             FRAME_START_O
);
  // registers and state
  logic [31:0]                 ctrl_reg;
  logic [31:0]                 cfg_reg;
  logic [15:0]                 fcnt_reg;
  logic [15:0]                 cyc_reg;
  logic [15:0]                 cyc_next;
  logic [alf_pkg::FRAME_W-1:0] hold_reg;
  logic                        wait_reg;
  logic [31:0]                 rdata_reg;
  alf_pkg::alf_state_t         state_reg;
  alf_pkg::alf_state_t         state_next;
  // decoded access
  logic                        req;
  logic                        wr_ack;
  logic                        no_div;
  logic                        frame_first;
  logic                        frame_clock;
  logic [alf_pkg::NUM_LANES-1:0] ser_rise;
  logic [alf_pkg::NUM_LANES-1:0] ser_fall;

  // byte-enable merge, shared by every writable register
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r & mask;
  endfunction

  alf_plan_if plan ();

  // configuration fields towards the planner
  assign plan.dlog     = cfg_reg[alf_pkg::CFG_DLOG_LSB +: 4];
  assign plan.res32    = cfg_reg[alf_pkg::CFG_RES_BIT];
  assign plan.cplx     = cfg_reg[alf_pkg::CFG_CPLX_BIT];
  assign plan.bands_m1 = cfg_reg[alf_pkg::CFG_BANDS_LSB +: 2];

  alf_lane_calc u_calc (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .pl      (plan.planner)
  );

  alf_lane_ser u_ser (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .load_i  (frame_first),
    .res32_i (plan.res32),
    .lanes_i ((state_reg == alf_pkg::ST_SERIAL) ? (plan.frac ? 5'h01 : plan.lanes) : 5'h00),
    .words_i (hold_reg),
    .rise_o  (ser_rise),
    .fall_o  (ser_fall)
  );

  // one wait cycle per access keeps the read mux off the address path
  assign req    = AVS_READ_I | AVS_WRITE_I;
  assign wr_ack = AVS_WRITE_I & ~wait_reg;
  assign no_div = plan.frac & ~ctrl_reg[alf_pkg::CTRL_DIV_BIT];   // host did not enable divider

  // waitrequest: high while idle, low for the accepting cycle
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      wait_reg <= 1'b1;
    else
      wait_reg <= ~(req & wait_reg);
  end

  // read data captured one edge before acceptance; unmapped reads zero
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_reg <= 32'h0000_0000;
    end else if (AVS_READ_I & wait_reg) begin
      unique case (AVS_ADDRESS_I)
        alf_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
        alf_pkg::ADDR_CFG:  rdata_reg <= cfg_reg;
        alf_pkg::ADDR_STAT: rdata_reg <= 32'({plan.lanes, no_div, plan.err, plan.frac,
                                              state_reg == alf_pkg::ST_SERIAL});
        alf_pkg::ADDR_FLEN: rdata_reg <= 32'(plan.flen);
        alf_pkg::ADDR_FCNT: rdata_reg <= 32'(fcnt_reg);
        default:            rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // control register: enable and bit clock divider enable
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      ctrl_reg <= alf_pkg::CTRL_RST;
    else if (wr_ack && AVS_ADDRESS_I == alf_pkg::ADDR_CTRL)
      ctrl_reg <= be_merge(ctrl_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I, alf_pkg::CTRL_MASK);
  end

  // configuration register: decimation, resolution, complex, bands
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      cfg_reg <= alf_pkg::CFG_RST;
    else if (wr_ack && AVS_ADDRESS_I == alf_pkg::ADDR_CFG)
      cfg_reg <= be_merge(cfg_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I, alf_pkg::CFG_MASK);
  end

  // mode selection from enable and lane plan
  always_comb begin
    if (!ctrl_reg[alf_pkg::CTRL_EN_BIT])
      state_next = alf_pkg::ST_IDLE;
    else if (plan.dlog == alf_pkg::DLOG_BYPASS)
      state_next = alf_pkg::ST_BYPASS;
    else if (plan.err || no_div)
      state_next = alf_pkg::ST_FAULT;
    else
      state_next = alf_pkg::ST_SERIAL;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      state_reg <= alf_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // frame position counter; restarts whenever serial mode is left
  assign frame_first = (state_reg == alf_pkg::ST_SERIAL) && (cyc_reg == 16'h0000);
  assign frame_clock        = cyc_reg < (plan.flen >> 1);                 // high first half of frame

  // at-or-past test: a shorter frame set mid-frame must not run the count around
  always_comb begin
    cyc_next = cyc_reg + 16'h0001;
    if (state_reg != alf_pkg::ST_SERIAL || cyc_next >= plan.flen)
      cyc_next = 16'h0000;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      cyc_reg <= 16'h0000;
    else
      cyc_reg <= cyc_next;
  end

  // band words held until the next BAND_LOAD_I; stale words repeat
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      hold_reg <= '0;
    else if (BAND_LOAD_I)
      hold_reg <= BAND_DATA_I;
  end

  // frames sent, wraps
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      fcnt_reg <= 16'h0000;
    else if (frame_first)
      fcnt_reg <= fcnt_reg + 16'h0001;
  end

  // lane drivers: ddr sample pair in bypass, framed bits in serial
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LANE_RISE_O <= '0;
      LANE_FALL_O <= '0;
    end else begin
      unique case (state_reg)
        alf_pkg::ST_BYPASS: begin
          LANE_RISE_O <= SMP_A_I;
          LANE_FALL_O <= SMP_B_I;
        end
        alf_pkg::ST_SERIAL: begin
          LANE_RISE_O <= ser_rise;
          LANE_FALL_O <= ser_fall;
          LANE_RISE_O[alf_pkg::FRAME_CLOCK_LANE] <= frame_clock;
          LANE_FALL_O[alf_pkg::FRAME_CLOCK_LANE] <= frame_clock;
        end
        alf_pkg::ST_IDLE, alf_pkg::ST_FAULT: begin
          LANE_RISE_O <= '0;
          LANE_FALL_O <= '0;
        end
      endcase
    end
  end

  // status pins follow the lanes by the same one edge
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SERIAL_OUTPUT_MODE_O <= 1'b0;
      BIT_CLK_DIV_O        <= 1'b0;
      FRAME_START_O        <= 1'b0;
    end else begin
      SERIAL_OUTPUT_MODE_O <= (state_reg == alf_pkg::ST_SERIAL);
      BIT_CLK_DIV_O        <= (state_reg == alf_pkg::ST_SERIAL) && plan.frac;   // dout/2 bit clock
      FRAME_START_O        <= frame_first;
    end
  end

  // bus answer straight from flops
  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
endmodule // alf_framer

// ===== logic/alf_pkg.sv
/*
  alf_pkg: shared constants for the lvds output framer.
  assumes: one 50 mhz clock; each clock cycle stands for one data bit clock period.
*/
package alf_pkg;
  // geometry
  localparam int unsigned NUM_LANES  = 16;
  localparam int unsigned NUM_WORDS  = 8;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned SAMPLE_W   = 16;
  localparam int unsigned FRAME_W    = NUM_WORDS * WORD_W;
  localparam int unsigned FRAME_CLOCK_LANE  = 0;
  localparam int unsigned TOP_LANE   = 15;
  localparam logic [4:0]  MAX_DATA_LANES = 5'h0f;
  localparam logic [2:0]  LANE_MUL   = 3'h3;   // lane count is 8 x k, a shift by 3
  localparam logic [3:0]  DLOG_BYPASS = 4'h0;
  localparam logic [1:0]  MAX_REAL_BANDS_M1 = 2'h1;

  // avalon register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG  = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_FLEN = 8'h0c;
  localparam logic [7:0] ADDR_FCNT = 8'h10;

  // ctrl fields
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_DIV_BIT = 1;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK    = 32'h0000_0003;

  // cfg fields
  localparam int unsigned CFG_DLOG_LSB  = 0;
  localparam int unsigned CFG_RES_BIT   = 4;
  localparam int unsigned CFG_CPLX_BIT  = 5;
  localparam int unsigned CFG_BANDS_LSB = 6;
  localparam logic [31:0] CFG_RST       = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK      = 32'h0000_00ff;

  // stat fields
  localparam int unsigned STAT_SER_BIT   = 0;
  localparam int unsigned STAT_FRAC_BIT  = 1;
  localparam int unsigned STAT_ERR_BIT   = 2;
  localparam int unsigned STAT_NODIV_BIT = 3;
  localparam int unsigned STAT_LANE_LSB  = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_BYPASS, ST_SERIAL, ST_FAULT} alf_state_t;
endpackage

// ===== logic/alf_plan_if.sv
/*
  alf_plan_if: carries the output configuration to the lane planner and the
  resulting lane plan back.
  assumes: planner and framer share one clock.
*/
`timescale 1ns/1ns
interface alf_plan_if;
  logic [3:0]  dlog;      // log2 of decimation, 0 = bypass
  logic        res32;     // 32-bit output resolution
  logic        cplx;      // complex decimation
  logic [1:0]  bands_m1;  // band count minus one
  logic [4:0]  lanes;     // data lanes, 0 means below one lane
  logic        frac;      // below one lane
  logic        err;       // illegal combination
  logic [15:0] flen;      // frame length in bit clock periods

  modport framer  (output dlog, res32, cplx, bands_m1, input lanes, frac, err, flen);
  modport planner (input dlog, res32, cplx, bands_m1, output lanes, frac, err, flen);
endinterface

// ===== logic/alf_lane_calc.sv
/*
  alf_lane_calc: derives lane count, frame length and legality from the
  resolution, band count, real/complex and decimation settings.
  assumes: settings held stable by the framer; result lags by one clock.
*/
`timescale 1ns/1ns
module alf_lane_calc (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // plan link
  alf_plan_if.planner pl
);
  logic [4:0]  k;
  logic [7:0]  k8;
  logic [7:0]  lanes_full;
  logic [22:0] back;
  logic        err_next;

  // k = r x b x c, lanes = 8 x k / d
  always_comb begin
    k          = 5'(({3'h0, pl.bands_m1} + 5'h01) << ({1'b0, pl.res32} + {1'b0, pl.cplx}));
    k8         = 8'({k, 3'h0});
    lanes_full = k8 >> pl.dlog;
    back       = 23'({15'h0, lanes_full}) << pl.dlog;
    err_next   = 1'b0;
    if (pl.dlog != alf_pkg::DLOG_BYPASS) begin
      if (lanes_full > 8'(alf_pkg::MAX_DATA_LANES))                 // at most 15 data lanes
        err_next = 1'b1;
      if (!pl.cplx && (pl.bands_m1 > alf_pkg::MAX_REAL_BANDS_M1))    // real allows one band per channel
        err_next = 1'b1;
      if ((lanes_full != 8'h00) && (back != 23'(k8)))                // non-integer lane count above one is unusable
        err_next = 1'b1;
    end
  end

  // plan registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pl.lanes <= 5'h00;
      pl.frac  <= 1'b0;
      pl.err   <= 1'b0;
      pl.flen  <= 16'h0000;
    end else begin
      pl.lanes <= lanes_full[4:0];
      pl.frac  <= (lanes_full == 8'h00);
      pl.err   <= err_next;
      // frame = d bit clocks at or above one lane, else 8 x k divided ones
      pl.flen  <= (lanes_full == 8'h00) ? 16'(k8) : 16'(17'h00001 << pl.dlog);
    end
  end
endmodule // alf_lane_calc

// ===== logic/alf_lane_ser.sv
/*
  alf_lane_ser: frame shift register; builds the msb-first frame stream from
  the held band words and hands out two bits per active lane each cycle.
  assumes: load on the first cycle of a frame, shift on every other one.
*/
`timescale 1ns/1ns
module alf_lane_ser (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // control
  input  wire logic                        load_i,
  input  wire logic                        res32_i,
  input  wire logic [4:0]                  lanes_i,
  input  wire logic [alf_pkg::FRAME_W-1:0] words_i,
  // lane bits for this bit clock period
  output logic [alf_pkg::NUM_LANES-1:0]    rise_o,
  output logic [alf_pkg::NUM_LANES-1:0]    fall_o
);
  logic [alf_pkg::FRAME_W-1:0] stream;
  logic [alf_pkg::FRAME_W-1:0] pick;
  logic [alf_pkg::FRAME_W-1:0] frame_reg;

  // word order b0i,b0q,b1i.. or b0,b1..: word 0 goes out first
  always_comb begin
    stream = '0;
    for (int w = 0; w < alf_pkg::NUM_WORDS; w++) begin
      if (res32_i)
        stream[alf_pkg::FRAME_W-1-w*alf_pkg::WORD_W -: alf_pkg::WORD_W] = words_i[w*alf_pkg::WORD_W +: alf_pkg::WORD_W];
      else
        stream[alf_pkg::FRAME_W-1-w*alf_pkg::SAMPLE_W -: alf_pkg::SAMPLE_W] =
          words_i[w*alf_pkg::WORD_W +: alf_pkg::SAMPLE_W];
    end
    pick = load_i ? stream : frame_reg;
  end

  // lane top-j takes the next bit pair: odd bit on rise, even on fall
  always_comb begin
    rise_o = '0;
    fall_o = '0;
    for (int j = 0; j < alf_pkg::NUM_LANES - 1; j++) begin
      if (5'(j) < lanes_i) begin
        rise_o[alf_pkg::TOP_LANE-j] = pick[alf_pkg::FRAME_W-1-2*j];
        fall_o[alf_pkg::TOP_LANE-j] = pick[alf_pkg::FRAME_W-2-2*j];
      end
    end
  end

  // consume 2 x lanes bits per bit clock period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      frame_reg <= '0;
    else
      frame_reg <= pick << {lanes_i, 1'b0};
  end
endmodule // alf_lane_ser

// ===== dv/alf_framer_monitor.sv
/*
  alf_framer_monitor: port-level assertions for the lvds output framer.
  assumes: bound to alf_framer; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ns
module alf_framer_monitor (
  // clock, reset and bus
  input wire logic        REF_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [7:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic        AVS_WAITREQUEST_O,
  // samples and lanes
  input wire logic [15:0] SMP_A_I,
  input wire logic [15:0] SMP_B_I,
  input wire logic [15:0] LANE_RISE_O,
  input wire logic [15:0] LANE_FALL_O,
  input wire logic        SERIAL_OUTPUT_MODE_O,
  input wire logic        BIT_CLK_DIV_O,
  input wire logic        FRAME_START_O
);
  logic       en_reg;
  logic [3:0] dlog_reg;
  logic [2:0] stab_reg;
  logic       byp;
  // mirror of enable and decimation; settle count because lanes lag a write by 3
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_reg   <= 1'b0;
      dlog_reg <= 4'h0;
      stab_reg <= 3'h0;
    end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[7:3] == 5'h00) begin
      stab_reg <= 3'h0;
      if (AVS_ADDRESS_I[2]) dlog_reg <= AVS_WRITEDATA_I[3:0];
      else en_reg <= AVS_WRITEDATA_I[0];
    end else if (stab_reg != 3'h7) begin
      stab_reg <= stab_reg + 3'h1;
    end
  end
  assign byp = (stab_reg == 3'h7) && en_reg && (dlog_reg == 4'h0);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  AST_WAIT_ANSWER: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("waitrequest did not drop one cycle after request");
  AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low longer than one cycle");
  AST_BYP_RISE: assert property (byp |-> LANE_RISE_O == $past(SMP_A_I))
    else $error("bypass rise lanes differ from channel a");
  AST_BYP_FALL: assert property (byp |-> LANE_FALL_O == $past(SMP_B_I))
    else $error("bypass fall lanes differ from channel b");
  AST_BYP_NOSER: assert property (byp |-> !SERIAL_OUTPUT_MODE_O && !FRAME_START_O)
    else $error("serial framing seen in bypass");
  AST_FRAME_CLOCK_START: assert property (FRAME_START_O |-> LANE_RISE_O[0] && LANE_FALL_O[0] && SERIAL_OUTPUT_MODE_O)
    else $error("frame clock low at frame start");
  AST_START_GAP: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame start lasted two cycles");
  AST_DIV_ONE_LANE: assert property (BIT_CLK_DIV_O |-> SERIAL_OUTPUT_MODE_O && LANE_RISE_O[14:1] == 14'h0 && LANE_FALL_O[14:1] == 14'h0)
    else $error("divided bit clock uses more than the top lane");
  AST_FRAME_CLOCK_RISE: assert property ($rose(LANE_RISE_O[0]) && SERIAL_OUTPUT_MODE_O |-> FRAME_START_O)
    else $error("frame clock rose away from frame start");
  // main scenarios reached
  cover property (FRAME_START_O && BIT_CLK_DIV_O);
  cover property (byp);
  cover property (FRAME_START_O ##2 FRAME_START_O);
endmodule // alf_framer_monitor
bind alf_framer alf_framer_monitor alf_framer_monitor_i (.REF_CLK_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_WAITREQUEST_O, .SMP_A_I, .SMP_B_I, .LANE_RISE_O, .LANE_FALL_O,
  .SERIAL_OUTPUT_MODE_O, .BIT_CLK_DIV_O, .FRAME_START_O);

// ===== dv/alf_rx_model.sv
/*
  alf_rx_model: receiver model; deserialises the top data lane and keeps
  the last whole frame, aligned on the rising frame clock.
  assumes: one clock per bit clock period, frame clock on lane zero.
*/
`timescale 1ns/1ns
module alf_rx_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // lanes from the framer
  input  wire logic [15:0] rise_i,
  input  wire logic [15:0] fall_i,
  // last frame of the top lane
  output logic      [63:0] frame_o
);
  logic [63:0] shift_reg;
  logic        frame_clock_reg;
  // rise bit then fall bit; word boundary taken at frame clock rise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= 64'h0;
      frame_clock_reg  <= 1'b0;
      frame_o   <= 64'h0;
    end else begin
      shift_reg <= {shift_reg[61:0], rise_i[15], fall_i[15]};
      frame_clock_reg  <= rise_i[0];
      if (rise_i[0] && !frame_clock_reg) frame_o <= shift_reg;
    end
  end
endmodule // alf_rx_model

// ===== dv/testbench.sv
/*
  testbench: random and corner stimulus for alf_framer over avalon and lanes.
  assumes: design under logic/, receiver model and bound monitor under dv/.
*/
`timescale 1ns/1ns
module testbench;
  logic         clk, rst_n, rd, wr, band_ld, rand_on;
  logic         waitreq, ser, div, fstart;
  logic [7:0]   addr;
  logic [31:0]  wdata, rdata, q;
  logic [15:0]  smp_a, smp_b, rise, fall, a_exp, b_exp;
  logic [255:0] band;
  logic [63:0]  rx_frame;
  logic [9:0]   tbl [9] = '{10'h143, 10'h164, 10'h1e3, 10'h101, 10'h378, 10'h183, 10'h1e1, 10'h1a5, 10'h157};
  int           n_errors, checks, seed;

  alf_framer alf_framer_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .SMP_A_I(smp_a), .SMP_B_I(smp_b), .BAND_DATA_I(band), .BAND_LOAD_I(band_ld),
    .LANE_RISE_O(rise), .LANE_FALL_O(fall), .SERIAL_OUTPUT_MODE_O(ser), .BIT_CLK_DIV_O(div),
    .FRAME_START_O(fstart));
  alf_rx_model alf_rx_model_i (.clk_i(clk), .rst_n_i(rst_n), .rise_i(rise), .fall_i(fall), .frame_o(rx_frame));

  // free-running clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // fresh random samples every cycle once enabled
  always @(posedge clk) begin
    if (rand_on) begin
      smp_a <= 16'($random(seed));
      smp_b <= 16'($random(seed));
    end
  end

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // one avalon access; held until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  // frame stream bit n: words in send order, msb first
  function automatic logic sbit(input int n, input int w);
    return band[(n / w) * 32 + (w - 1 - n % w)];
  endfunction

  task automatic run_cfg(input logic [7:0] c, input logic [1:0] ctl);
    int k, l, le, flen, w;
    logic bad;
    k    = (int'(c[7:6]) + 1) << (int'(c[4]) + int'(c[5]));
    l    = (8 * k) >> c[3:0];
    bad  = l > 15 || (!c[5] && c[7:6] > 2'h1) || (l != 0 && ((8 * k) % (1 << c[3:0])) != 0);
    le   = (l == 0) ? 1 : l;
    flen = (l == 0) ? 8 * k : (1 << c[3:0]);
    w    = c[4] ? 32 : 16;
    av(1'b1, alf_pkg::ADDR_CTRL, {30'h0, ctl});
    av(1'b1, alf_pkg::ADDR_CFG, {24'h0, c});
    repeat (6) tick;
    av(1'b0, alf_pkg::ADDR_STAT, 32'h0);
    if (bad) cmp(q[2], 1'b1);
    else if (l == 0 && !ctl[1]) cmp(q[3], 1'b1);
    else begin
      cmp(q[8:4], 5'(l));
      cmp(q[0], 1'b1);
      cmp(div, l == 0);
      av(1'b0, alf_pkg::ADDR_FLEN, 32'h0);
      cmp(q, 32'(flen));
      // skip the frame in flight and the next whole one, check the one after
      repeat (2) begin
        tick;
        while (fstart !== 1'b1) tick;
      end
      for (int p = 0; p < flen; p++) begin
        for (int j = 0; j < le; j++) begin
          cmp(rise[15 - j], sbit(p * 2 * le + 2 * j, w));
          cmp(fall[15 - j], sbit(p * 2 * le + 2 * j + 1, w));
        end
        cmp({rise[0], fall[0]}, (p < flen / 2) ? 2'h3 : 2'h0);
        tick;
      end
    end
    $display("test cfg %h ctrl %h done", c, ctl);
  endtask

  task automatic finish_test;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #1000000;
    n_errors++;
    finish_test;
  end

  initial begin
    seed = 32'h41de2258;
    {rst_n, rd, wr, band_ld, rand_on, addr, wdata, smp_a, smp_b} = '0;
    for (int i = 0; i < 8; i++) band[i * 32 +: 32] = $random(seed);
    repeat (3) @(posedge clk);
    #1;
    cmp(waitreq, 1'b1);
    cmp({rise, fall}, 32'h0000_0000);
    cmp({ser, fstart, div}, 3'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    band_ld <= 1'b1;
    @(posedge clk);
    band_ld <= 1'b0;
    #1;
    av(1'b0, alf_pkg::ADDR_CTRL, 32'h0);
    cmp(q, alf_pkg::CTRL_RST);
    av(1'b0, alf_pkg::ADDR_CFG, 32'h0);
    cmp(q, alf_pkg::CFG_RST);
    av(1'b1, alf_pkg::ADDR_CFG, 32'hffff_ff5a);
    av(1'b0, alf_pkg::ADDR_CFG, 32'h0);
    cmp(q, 32'h0000_005a);
    av(1'b1, 8'h20, 32'hffff_ffff);
    av(1'b0, 8'h20, 32'h0);
    cmp(q, 32'h0);
    $display("test registers done");
    // bypass with random samples
    av(1'b1, alf_pkg::ADDR_CTRL, 32'h1);
    av(1'b1, alf_pkg::ADDR_CFG, 32'h0);
    rand_on = 1'b1;
    repeat (6) tick;
    repeat (20) begin
      a_exp = smp_a;
      b_exp = smp_b;
      tick;
      cmp(rise, a_exp);
      cmp(fall, b_exp);
    end
    av(1'b1, alf_pkg::ADDR_CTRL, 32'h0);
    repeat (6) tick;
    cmp({rise, ser}, 17'h0);
    $display("test bypass done");
    foreach (tbl[i]) run_cfg(tbl[i][7:0], tbl[i][9:8]);
    // single-lane real 32-bit, seen whole by the receiver model
    run_cfg(8'h57, 2'h3);
    tick;
    cmp(rx_frame[63:32], band[31:0]);
    cmp(rx_frame[31:0], band[63:32]);
    finish_test;
  end
endmodule // testbench
